/* File: shared/eeprom_wr_map.svh */
// Purpose: Constants for the two-wire EEPROM write front end.
// Assumes: Core clock period and write time given in nanoseconds.
// Notes:   Definitions only; included by bare name.
`ifndef EEPROM_WR_MAP_SVH
`define EEPROM_WR_MAP_SVH

// Fixed device code in the top nibble of the control byte.
`define DEV_CODE       4'ha
// Control byte field positions.
`define CTL_CODE_HI    7
`define CTL_CODE_LO    4
`define CTL_SEL_HI     3
`define CTL_SEL_LO     1
`define CTL_RW_BIT     0
// Core clock period in ns.
`define CORE_CLK_NS    10
// Internal write cycle time in ns.
`define TWC_NS         4000000
// Bits per byte before the acknowledge slot.
`define BITS_PER_BYTE  4'h8

`endif

/* File: shared/eeprom_wr_pkg.sv */
// Purpose: Types shared by the EEPROM write front end.
// Assumes: Constants come from the map header.
// Notes:   States follow a Gray path through a write with two address bytes.
`default_nettype none

package eeprom_wr_pkg;

	// Command decoder states.
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_CTRL   = 3'h1,
		ST_ADR_HI = 3'h3,
		ST_ADR_LO = 3'h2,
		ST_DATA   = 3'h6,
		ST_IGNORE = 3'h7
	} dec_state_t;

	// Bus conditions seen in the core domain.
	typedef struct packed {
		logic start;
		logic stop;
		logic scl_fall;
		logic bit_ev;
	} bus_cond_t;

endpackage : eeprom_wr_pkg

`default_nettype wire

/* File: hw/eeprom_wr_front.sv */
// Purpose: Two-wire slave front end of a serial EEPROM, write side.
// Assumes: The bus master drives the serial clock and conditions.
// Notes:   Bits are sampled on the serial clock; decoding runs on core.
`default_nettype none

`include "eeprom_wr_map.svh"

module eeprom_wr_front #(
	parameter int          ADDR_W     = 16, // Array address width.
	parameter int          PAGE_BYTES = 64, // Page buffer size.
	parameter bit          TWO_ADR    = 1'b1, // Two address bytes.
	parameter logic [2:0]  CS_MASK    = 3'h7, // Select bits vs pins.
	parameter logic [18:0] WP_LO      = 19'h00000, // Protected low.
	parameter logic [18:0] WP_HI      = 19'h7ffff, // Protected high.
	parameter int          TWC_CYC    = `TWC_NS / `CORE_CLK_NS
) (
	input  wire logic              core_clk_in,  // Core clock.
	input  wire logic              rst_in,       // Sync reset, high.
	input  wire logic              scl_clk_in,   // Serial clock.
	input  wire logic              scl_in,       // Serial clock level.
	input  wire logic              sda_in,       // Data line level.
	input  wire logic              wp_in,        // Write protect.
	input  wire logic [2:0]        chip_select_pins_in, // Pin levels.
	output logic                   sda_out,      // Data drive value.
	output logic                   sda_oe_out,   // Data drive enable.
	output logic                   busy_out,     // Write cycle runs.
	output logic [ADDR_W-1:0]      addr_out      // Address counter.
);

	localparam int PG_W = $clog2(PAGE_BYTES);
	localparam int BC_W = $clog2(TWC_CYC + 1);

	// Builds the raw address from select bits and address bytes.
	function automatic logic [18:0] build_addr(
		input logic [2:0] blk,
		input logic [7:0] hi,
		input logic [7:0] lo
	);
		build_addr = TWO_ADR ? {blk, hi, lo} : {8'h00, blk, lo};
	endfunction : build_addr

	// ---------------- Link domain ----------------
	logic       lrst_s1_r;
	logic       lrst_s2_r;
	logic [7:0] lsh_r;
	logic [7:0] lsh_nxt;
	logic       ltgl_r;
	logic       ltgl_nxt;

	// Each rising serial clock shifts a bit and, outside link reset, flips the event toggle.
	always_comb begin
		lsh_nxt  = {lsh_r[6:0], sda_in};
		ltgl_nxt = lrst_s2_r ? 1'b0 : ~ltgl_r;
	end

	// Reset reaches this domain only while the serial clock runs.
	always_ff @(posedge scl_clk_in) begin
		lrst_s1_r <= rst_in;
		lrst_s2_r <= lrst_s1_r;
		lsh_r     <= lsh_nxt;
		ltgl_r    <= ltgl_nxt;
	end

	// ---------------- Core synchronisers ----------------
	logic       scl_s1_r;
	logic       scl_s2_r;
	logic       scl_d_r;
	logic       sda_s1_r;
	logic       sda_s2_r;
	logic       sda_d_r;
	logic       tgl_s1_r;
	logic       tgl_s2_r;
	logic       tgl_d_r;
	logic       tgl_dd_r;
	logic       wp_s1_r;
	logic       wp_s2_r;
	logic [2:0] cs_s1_r;
	logic [2:0] cs_s2_r;
	logic [7:0] cap_s1_r;
	logic [7:0] cap_s2_r;

	// Pins and link words pass two flops before any logic.
	always_ff @(posedge core_clk_in) begin
		scl_s1_r <= scl_in;
		scl_s2_r <= scl_s1_r;
		scl_d_r  <= scl_s2_r;
		sda_s1_r <= sda_in;
		sda_s2_r <= sda_s1_r;
		sda_d_r  <= sda_s2_r;
		tgl_s1_r <= ltgl_r;
		tgl_s2_r <= tgl_s1_r;
		tgl_d_r  <= tgl_s2_r;
		tgl_dd_r <= tgl_d_r;
		wp_s1_r  <= wp_in;
		wp_s2_r  <= wp_s1_r;
		cs_s1_r  <= chip_select_pins_in;
		cs_s2_r  <= cs_s1_r;
		cap_s1_r <= lsh_r;
		cap_s2_r <= cap_s1_r;
	end

	// The bit event lags the word by a cycle so the word is settled.
	eeprom_wr_pkg::bus_cond_t cond;
	always_comb begin
		cond.start    = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
		cond.stop     = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
		cond.scl_fall = scl_d_r & ~scl_s2_r;
		cond.bit_ev   = tgl_d_r ^ tgl_dd_r;
	end

	// ---------------- Decoder state ----------------
	eeprom_wr_pkg::dec_state_t state_r;
	eeprom_wr_pkg::dec_state_t state_nxt;
	logic [3:0]            cnt_r;
	logic [3:0]            cnt_nxt;
	logic                  ack_r;
	logic                  ack_nxt;
	logic                  oe_r;
	logic                  oe_nxt;
	logic [2:0]            blk_r;
	logic [2:0]            blk_nxt;
	logic [7:0]            hi_r;
	logic [7:0]            hi_nxt;
	logic [ADDR_W-1:0]     ctr_r;
	logic [ADDR_W-1:0]     ctr_nxt;
	logic                  got_r;
	logic                  got_nxt;
	logic [PAGE_BYTES-1:0] mask_r;
	logic [PAGE_BYTES-1:0] mask_nxt;
	logic                  busy_r;
	logic                  busy_nxt;
	logic [BC_W-1:0]       bcnt_r;
	logic [BC_W-1:0]       bcnt_nxt;
	logic                  byte_ev;
	logic                  buf_we;
	logic                  prot;
	logic                  commit_ok;
	logic                  commit_go;
	logic                  sel_ok;
	logic [18:0]           page_base;
	logic [7:0]            word;

	logic [7:0] mem_r [2**ADDR_W];
	logic [7:0] pbuf_r [PAGE_BYTES];

	assign word    = cap_s2_r;
	assign byte_ev = cond.bit_ev && (cnt_r == `BITS_PER_BYTE - 4'h1);

	// chip-select pin compare
	// The select compare only looks at bits that are pin backed.
	assign sel_ok = (word[`CTL_CODE_HI:`CTL_CODE_LO] == `DEV_CODE) &&
		(((word[`CTL_SEL_HI:`CTL_SEL_LO] ^ cs_s2_r) & CS_MASK) == 3'h0);

	assign page_base = 19'(ctr_r);
	assign prot      = wp_s2_r && (page_base >= WP_LO) &&
		(page_base <= WP_HI);

	assign commit_ok = (state_r == eeprom_wr_pkg::ST_DATA) && got_r
		&& !prot;
	assign commit_go = cond.stop && commit_ok;

	// Busy timer counts the internal write cycle.
	// busy timer model
	always_comb begin
		busy_nxt = busy_r;
		bcnt_nxt = bcnt_r;
		if (commit_go) begin
			busy_nxt = 1'b1;
			bcnt_nxt = '0;
		end else if (busy_r) begin
			bcnt_nxt = bcnt_r + BC_W'(1);
			if (bcnt_r == BC_W'(TWC_CYC - 1)) begin
				busy_nxt = 1'b0;
			end
		end
	end

	// Decoder next state, address counter and acknowledge slot.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		ack_nxt   = ack_r;
		oe_nxt    = oe_r;
		blk_nxt   = blk_r;
		hi_nxt    = hi_r;
		ctr_nxt   = ctr_r;
		got_nxt   = got_r;
		mask_nxt  = mask_r;
		buf_we    = 1'b0;
		if (cond.start) begin
			state_nxt = eeprom_wr_pkg::ST_CTRL;
			cnt_nxt   = 4'h0;
			ack_nxt   = 1'b0;
			oe_nxt    = 1'b0;
			got_nxt   = 1'b0;
			mask_nxt  = '0;
		end else if (cond.stop) begin
			state_nxt = eeprom_wr_pkg::ST_IDLE;
			cnt_nxt   = 4'h0;
			ack_nxt   = 1'b0;
			oe_nxt    = 1'b0;
			got_nxt   = 1'b0;
			mask_nxt  = '0;
		end else begin
			if (cond.scl_fall) begin
				if (cnt_r == `BITS_PER_BYTE && ack_r) begin
					oe_nxt = 1'b1;
				end else if (cnt_r == 4'h0 && oe_r) begin
					oe_nxt  = 1'b0;
					ack_nxt = 1'b0;
				end
			end
			if (cond.bit_ev) begin
				if (cnt_r == `BITS_PER_BYTE) begin
					cnt_nxt = 4'h0;
				end else begin
					cnt_nxt = cnt_r + 4'h1;
				end
			end
			if (byte_ev) begin
				case (state_r)
					eeprom_wr_pkg::ST_CTRL: begin
						if (sel_ok && !busy_r) begin
							ack_nxt = 1'b1;
							if (word[`CTL_RW_BIT]) begin
								state_nxt = eeprom_wr_pkg::ST_IGNORE;
							end else if (TWO_ADR) begin
								state_nxt = eeprom_wr_pkg::ST_ADR_HI;
							end else begin
								state_nxt = eeprom_wr_pkg::ST_ADR_LO;
							end
							blk_nxt = word[`CTL_SEL_HI:`CTL_SEL_LO];
						end else begin
							ack_nxt   = 1'b0;
							state_nxt = eeprom_wr_pkg::ST_IGNORE;
						end
					end
					eeprom_wr_pkg::ST_ADR_HI: begin
						ack_nxt   = 1'b1;
						hi_nxt    = word;
						ctr_nxt   = ADDR_W'(build_addr(blk_r, word,
							8'h00));
						state_nxt = eeprom_wr_pkg::ST_ADR_LO;
					end
					eeprom_wr_pkg::ST_ADR_LO: begin
						ack_nxt   = 1'b1;
						ctr_nxt   = ADDR_W'(build_addr(blk_r, hi_r,
							word));
						state_nxt = eeprom_wr_pkg::ST_DATA;
					end
					eeprom_wr_pkg::ST_DATA: begin
						ack_nxt  = 1'b1;
						buf_we   = 1'b1;
						got_nxt  = 1'b1;
						mask_nxt[ctr_r[PG_W-1:0]] = 1'b1;
						ctr_nxt[PG_W-1:0] = ctr_r[PG_W-1:0] +
							PG_W'(1);
					end
					eeprom_wr_pkg::ST_IGNORE: begin
						ack_nxt = 1'b0;
					end
					default: begin
						ack_nxt   = 1'b0;
						state_nxt = eeprom_wr_pkg::ST_IGNORE;
					end
				endcase
			end
		end
	end

	// Decoder registers.
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state_r <= eeprom_wr_pkg::ST_IDLE;
			cnt_r   <= 4'h0;
			ack_r   <= 1'b0;
			oe_r    <= 1'b0;
			blk_r   <= 3'h0;
			hi_r    <= 8'h00;
			ctr_r   <= '0;
			got_r   <= 1'b0;
			mask_r  <= '0;
			busy_r  <= 1'b0;
			bcnt_r  <= '0;
			sda_out <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			ack_r   <= ack_nxt;
			oe_r    <= oe_nxt;
			blk_r   <= blk_nxt;
			hi_r    <= hi_nxt;
			ctr_r   <= ctr_nxt;
			got_r   <= got_nxt;
			mask_r  <= mask_nxt;
			busy_r  <= busy_nxt;
			bcnt_r  <= bcnt_nxt;
			sda_out <= 1'b0;
		end
	end

	// Outputs straight from the registers.
	assign sda_oe_out = oe_r;
	assign busy_out   = busy_r;
	assign addr_out   = ctr_r;

	// Page buffer takes bytes; a late page overwrites earlier ones.
	always_ff @(posedge core_clk_in) begin
		if (buf_we) begin
			pbuf_r[ctr_r[PG_W-1:0]] <= word;
		end
	end

	// The whole page lands in one cycle; untouched bytes keep value.
	// commit after stop
	always_ff @(posedge core_clk_in) begin
		if (commit_go) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (mask_r[i]) begin
					mem_r[{ctr_r[ADDR_W-1:PG_W], PG_W'(i)}] <= pbuf_r[i];
				end
			end
		end
	end

	// ---------------- Checks ----------------
	sequence s_ctrl_byte;
		byte_ev && (state_r == eeprom_wr_pkg::ST_CTRL);
	endsequence

	sequence s_ack_slot;
		cond.scl_fall && (cnt_r == `BITS_PER_BYTE) && ack_r;
	endsequence

	AST_START_RESETS: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		cond.start |=> (state_r == eeprom_wr_pkg::ST_CTRL) &&
			(cnt_r == 4'h0) && !oe_r)
		else $error("Start did not reset the decoder.");

	AST_STOP_IDLE: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		cond.stop |=> (state_r == eeprom_wr_pkg::ST_IDLE) && !got_r)
		else $error("Stop did not end the operation.");

	AST_CODE_MISMATCH: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		s_ctrl_byte ##0 (word[7:4] != `DEV_CODE) |=> !ack_r &&
			(state_r == eeprom_wr_pkg::ST_IGNORE))
		else $error("Foreign device code was acknowledged.");

	AST_BUSY_NO_ACK: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		s_ctrl_byte ##0 busy_r |=> !ack_r)
		else $error("Control byte acknowledged while busy.");

	AST_ACK_NINTH: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		s_ack_slot |=> oe_r ##0 (cnt_r == `BITS_PER_BYTE))
		else $error("Acknowledge not driven in ninth cycle.");

	AST_COMMIT_BUSY: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		commit_go |=> busy_r ##1 busy_r)
		else $error("Stop after data did not start write cycle.");

	AST_PROTECT_IDLE: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		cond.stop && !busy_r && (state_r == eeprom_wr_pkg::ST_DATA)
			&& prot |=> !busy_r)
		else $error("Protected write started a write cycle.");

	AST_BUSY_BOUND: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		busy_r |-> (32'(bcnt_r) < TWC_CYC))
		else $error("Write cycle ran past its time.");

	AST_PAGE_WRAP: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		byte_ev && (state_r == eeprom_wr_pkg::ST_DATA) &&
			!cond.start && !cond.stop |=>
			(ctr_r[ADDR_W-1:PG_W] == $past(ctr_r[ADDR_W-1:PG_W])))
		else $error("Page write left the current page.");

endmodule : eeprom_wr_front

`default_nettype wire

/* File: verif/two_wire_master_model.sv */
// Purpose: Bus master model that drives the serial clock and data line.
// Assumes: Paced on falling edges of the core clock, 10 ns per step.
// Notes:   Serial clock stands high between frames; a released data
//          line reads high through the pull-up.
`default_nettype none

module two_wire_master_model (
	input  wire logic clk_in,  // Core clock used for pacing.
	input  wire logic sda_in,  // Resolved data line level.
	output logic      scl_out, // Serial clock drive.
	output logic      sda_out  // Data drive, high means released.
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus: both lines high.
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end

	// Wait a number of falling core clock edges.
	task automatic wt(input int n);
		repeat (n) @(negedge clk_in);
	endtask : wt

	// Data changes only while the clock is low; sampled mid-high.
	task automatic bit_c(input logic b, output logic seen);
		sda_out = b;
		wt(16);
		scl_out = 1'b1;
		wt(6);
		seen = sda_in;
		wt(6);
		scl_out = 1'b0;
		wt(16);
	endtask : bit_c

	task automatic start_c();
		sda_out = 1'b1;
		wt(8);
		scl_out = 1'b1;
		wt(12);
		sda_out = 1'b0;
		wt(10);
		scl_out = 1'b0;
		wt(16);
	endtask : start_c

	task automatic stop_c();
		sda_out = 1'b0;
		wt(16);
		scl_out = 1'b1;
		wt(12);
		sda_out = 1'b1;
		// Return at once so the caller sees the write cycle start.
		wt(1);
	endtask : stop_c

	// bytes sent most significant bit first
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_c(b[i], s);
		end
		bit_c(1'b1, s);
		ack = ~s;
	endtask : wr_byte

	// Clock pulses with data high, so no condition is formed.
	task automatic idle_clk();
		repeat (4) begin
			scl_out = 1'b0;
			wt(30);
			scl_out = 1'b1;
			wt(10);
		end
	endtask : idle_clk
endmodule : two_wire_master_model

`default_nettype wire

/* File: verif/serial_eeprom_addressing_write_tb_top.sv */
// Purpose: Self-checking bench for the EEPROM write front end.
// Assumes: Write time shortened so a poll fits inside one write cycle.
// Notes:   Control byte cases run from a table; writes follow by hand.
`default_nettype none

module serial_eeprom_addressing_write_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int TWC = 2000;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [2:0] pins;
		logic       ack;
	} row_t;

	logic        core_clk;
	logic        rst;
	logic        wp;
	logic [2:0]  cs;
	logic        scl;
	logic        m_sda;
	logic        sda_line;
	logic        sda_drv;
	logic        sda_oe;
	logic        busy;
	logic [15:0] addr;
	logic        ack;
	int          n;
	int          miscompares;
	int          comparisons;
	row_t        rows [7];

	// Open drain: the device only ever pulls the line low.
	assign sda_line = m_sda & (~sda_oe | sda_drv);

	eeprom_wr_front #(.TWC_CYC(TWC)) i_eeprom_wr_front (
		.core_clk_in        (core_clk),
		.rst_in             (rst),
		.scl_clk_in         (scl),
		.scl_in             (scl),
		.sda_in             (sda_line),
		.wp_in              (wp),
		.chip_select_pins_in(cs),
		.sda_out            (sda_drv),
		.sda_oe_out         (sda_oe),
		.busy_out           (busy),
		.addr_out           (addr)
	);

	two_wire_master_model i_two_wire_master_model (
		.clk_in (core_clk),
		.sda_in (sda_line),
		.scl_out(scl),
		.sda_out(m_sda)
	);

	// Core clock, 10 ns period.
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic final_report();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	// Write command; the stop is optional so a restart can follow.
	task automatic wr_cmd(input logic [7:0] hi, input logic [7:0] lo,
			input int cnt, input logic stp);
		i_two_wire_master_model.start_c();
		i_two_wire_master_model.wr_byte(8'ha0, ack);
		check(ack, 1'b1);
		i_two_wire_master_model.wr_byte(hi, ack);
		check(ack, 1'b1);
		i_two_wire_master_model.wr_byte(lo, ack);
		check(ack, 1'b1);
		for (int k = 0; k < cnt; k++) begin
			i_two_wire_master_model.wr_byte(8'h5a + k[7:0], ack);
			check(ack, 1'b1);
		end
		if (stp) begin
			i_two_wire_master_model.stop_c();
		end
	endtask : wr_cmd

	// Give the write cycle a few cycles to start after the stop.
	task automatic wait_rise(input logic exp);
		for (int i = 0; i < 20 && busy !== 1'b1; i++) begin
			@(negedge core_clk);
		end
		check(busy, exp);
	endtask : wait_rise

	// Count busy cycles; a hung write cycle counts as a mismatch.
	task automatic wait_fall(output int cnt);
		cnt = 0;
		while (busy === 1'b1) begin
			cnt++;
			if (cnt > 3 * TWC) begin
				miscompares++;
				break;
			end
			@(negedge core_clk);
		end
	endtask : wait_fall

	// Poll with a write control byte and report the acknowledge.
	task automatic poll(output logic a);
		i_two_wire_master_model.start_c();
		i_two_wire_master_model.wr_byte(8'ha0, a);
		i_two_wire_master_model.stop_c();
	endtask : poll

	initial begin
		miscompares = 0;
		comparisons = 0;
		rst = 1'b1;
		wp = 1'b0;
		cs = 3'h0;
		rows = '{'{8'ha0, 3'h0, 1'b1}, '{8'hb0, 3'h0, 1'b0},
			'{8'ha2, 3'h0, 1'b0}, '{8'ha2, 3'h1, 1'b1},
			'{8'hae, 3'h7, 1'b1}, '{8'ha1, 3'h0, 1'b1},
			'{8'h20, 3'h0, 1'b0}};
		// Let the model's idle levels settle before the first pulse.
		@(negedge core_clk);
		i_two_wire_master_model.idle_clk();
		@(negedge core_clk);
		check({sda_oe, busy, addr}, 18'h0);
		rst = 1'b0;
		// The link reset lags release by two serial clock edges.
		i_two_wire_master_model.idle_clk();
		i_two_wire_master_model.wt(5);
		// Code, select pins and direction bit from the table.
		foreach (rows[i]) begin
			cs = rows[i].pins;
			i_two_wire_master_model.start_c();
			i_two_wire_master_model.wr_byte(rows[i].ctrl, ack);
			check(ack, rows[i].ack);
			i_two_wire_master_model.stop_c();
		end
		cs = 3'h0;
		// Byte write with protection off, timed end to end.
		// master keeps this write in one page.
		wr_cmd(8'h12, 8'h34, 1, 1'b1);
		wait_rise(1'b1);
		wait_fall(n);
		check(n, TWC);
		check(addr, 16'h1235);
		check(i_eeprom_wr_front.mem_r[16'h1234], 8'h5a);
		// Page write crossing a page end wraps inside the page.
		wr_cmd(8'h10, 8'h7e, 3, 1'b1);
		wait_rise(1'b1);
		poll(ack);
		check(ack, 1'b0);
		wait_fall(n);
		check(addr, 16'h1041);
		check(i_eeprom_wr_front.mem_r[16'h107e], 8'h5a);
		check(i_eeprom_wr_front.mem_r[16'h107f], 8'h5b);
		check(i_eeprom_wr_front.mem_r[16'h1040], 8'h5c);
		// Protected write: acknowledged, no write cycle.
		wp = 1'b1;
		wr_cmd(8'h00, 8'h20, 2, 1'b1);
		wait_rise(1'b0);
		poll(ack);
		check(ack, 1'b1);
		wp = 1'b0;
		// Stop before any data keeps only the address.
		wr_cmd(8'h05, 8'h06, 0, 1'b1);
		wait_rise(1'b0);
		check(addr, 16'h0506);
		// Restart mid-command resets the decoder.
		wr_cmd(8'h07, 8'h08, 1, 1'b0);
		i_two_wire_master_model.start_c();
		i_two_wire_master_model.wr_byte(8'ha0, ack);
		check(ack, 1'b1);
		i_two_wire_master_model.stop_c();
		wait_rise(1'b0);
		final_report();
	end
endmodule : serial_eeprom_addressing_write_tb_top

`default_nettype wire
